/* dpc_pkg.sv */
// Purpose: shared constants and types of the disperser profile block
// Assumes: one clock pclk at 10 MHz, asynchronous active-low reset presetn
// Notes: parameter source end is an APB slave, calculator end has no registers
package dpc_pkg;
  localparam int PIPE_W  = 8;
  localparam int SECM1_W = 5;
  localparam int MINT_W  = 4;
  localparam int MFR_W   = 4;
  localparam int UPC_W   = 12;
  localparam int SID_W   = 8;
  localparam int HALF_W  = 4;
  localparam int GAP_W   = 16;
  localparam int DIFF_W  = 8;
  localparam int LEN_W   = 16;
  localparam int TAP_W   = 24;
  localparam int NTAP    = 32;
  localparam int IDX_W   = 5;
  localparam int ROW_W   = 2;    // 4 rows
  localparam int COL_W   = 3;    // 8 columns
  localparam int FRACT_BITS = 4;
  localparam int LIST_W  = 9;
  localparam int NPIPE_W = 3;
  localparam int SEC_AW  = 6;
  // apb map of the parameter source
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] CTRL_OFS   = 12'h000; // wr bit0 start, rd bit0 busy
  localparam logic [11:0] COUNT_OFS  = 12'h004;
  localparam logic [11:0] SENT_OFS   = 12'h008;
  localparam logic [11:0] PIPE_BASE  = 12'h100; // two words per pipe
  localparam logic [11:0] SEC_BASE   = 12'h200; // one word per section
  localparam int CNT_NPM1_LSB = 0;
  localparam int CNT_NSEC_LSB = 8;
  localparam int PA_WIDTH_LSB = 0;
  localparam int PA_SECM1_LSB = 8;
  localparam int PA_MINT_LSB  = 16;
  localparam int PA_MFR_LSB   = 20;
  localparam int PA_INV_BIT   = 24;
  localparam int PA_TAIL_BIT  = 25;
  localparam int PA_ALIGN_BIT = 26;
  localparam int PA_RECFG_BIT = 27;
  localparam int PB_UPC_LSB   = 0;
  localparam int PB_SID_LSB   = 16;
  localparam int SE_HALF_LSB  = 0;
  localparam int SE_DIFF_LSB  = 8;
  localparam int SE_GAP_LSB   = 16;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [2:0] {C_IDLE, C_HDRS, C_SECS, C_TAPS, C_COMMIT} dpc_calc_state_t;
  typedef enum logic [1:0] {S_IDLE, S_HDR, S_SEC} dpc_src_state_t;
endpackage

/* dpc_link_if.sv */
`timescale 1ns/1ps
// Purpose: link between parameter source and profile calculator
// Assumes: both ends on pclk
// Notes: header stream per pipe, then the whole section list
interface dpc_link_if;
  logic                        hdr_valid;
  logic                        hdr_ready;
  logic                        hdr_last;
  logic                        list_empty;
  logic [dpc_pkg::PIPE_W-1:0]  pipe_width_units;
  logic [dpc_pkg::SECM1_W-1:0] sections_m1;
  logic [dpc_pkg::MINT_W-1:0]  mult_int_m1;
  logic [dpc_pkg::MFR_W-1:0]   mult_fract;
  logic                        invert;
  logic                        tail_pipe;
  logic                        codeword_align;
  logic                        reconfig_flag;
  logic [dpc_pkg::UPC_W-1:0]   units_per_codeword;
  logic [dpc_pkg::SID_W-1:0]   stream_identifier;
  logic                        sec_valid;
  logic                        sec_ready;
  logic                        sec_last;
  logic [dpc_pkg::HALF_W-1:0]  half_tap_count_m1;
  logic [dpc_pkg::GAP_W-1:0]   gap_width;
  logic [dpc_pkg::DIFF_W-1:0]  tap_diff;
  modport src (output hdr_valid, hdr_last, list_empty, pipe_width_units, sections_m1, mult_int_m1,
               mult_fract, invert, tail_pipe, codeword_align, reconfig_flag, units_per_codeword,
               stream_identifier, sec_valid, sec_last, half_tap_count_m1, gap_width, tap_diff,
               input hdr_ready, sec_ready);
  modport calc (input hdr_valid, hdr_last, list_empty, pipe_width_units, sections_m1, mult_int_m1,
                mult_fract, invert, tail_pipe, codeword_align, reconfig_flag, units_per_codeword,
                stream_identifier, sec_valid, sec_last, half_tap_count_m1, gap_width, tap_diff,
                output hdr_ready, sec_ready);
endinterface // dpc_link_if

/* dpc_param_source.sv */
`timescale 1ns/1ps
// Purpose: software-loaded signalling parameter source, streams them on the link
// Assumes: apb master keeps request stable until pready
// Notes: answers every transfer in its first access cycle
module dpc_param_source #(
  parameter int NPIPE = 8,
  parameter int NSEC  = 64
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [dpc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // link
  dpc_link_if.src                         link
);
  dpc_pkg::dpc_src_state_t state, next_state;
  logic [31:0] pipe_a [NPIPE];
  logic [31:0] pipe_b [NPIPE];
  logic [31:0] sec_mem [NSEC];
  logic [31:0] count_word, next_count_word;
  logic [31:0] sent, next_sent;
  logic [31:0] next_pipe_a [NPIPE];
  logic [31:0] next_pipe_b [NPIPE];
  logic [31:0] next_sec_mem [NSEC];
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic [dpc_pkg::NPIPE_W-1:0] p, next_p;
  logic [dpc_pkg::SEC_AW-1:0]  s, next_s;
  logic        hv, next_hv, sv, next_sv;
  logic [dpc_pkg::NPIPE_W-1:0] npm1;
  logic [dpc_pkg::SEC_AW:0]    nsec;
  logic        wr, rd, hit_pipe, hit_sec, hit_reg;
  logic [dpc_pkg::NPIPE_W-1:0] ap;
  logic [dpc_pkg::SEC_AW-1:0]  as;

  // register decode
  always_comb begin
    npm1     = count_word[dpc_pkg::CNT_NPM1_LSB +: dpc_pkg::NPIPE_W];
    nsec     = count_word[dpc_pkg::CNT_NSEC_LSB +: dpc_pkg::SEC_AW+1];
    ap       = paddr[3 +: dpc_pkg::NPIPE_W];
    as       = paddr[2 +: dpc_pkg::SEC_AW];
    hit_pipe = (paddr[11:8] == dpc_pkg::PIPE_BASE[11:8]) && (paddr[7:3] < 5'(NPIPE)) && (paddr[1:0] == 2'h0);
    hit_sec  = (paddr[11:8] == dpc_pkg::SEC_BASE[11:8]) && (paddr[1:0] == 2'h0);
    hit_reg  = (paddr == dpc_pkg::CTRL_OFS) || (paddr == dpc_pkg::COUNT_OFS) || (paddr == dpc_pkg::SENT_OFS);
    wr       = psel && penable && pready && pwrite;
    rd       = psel && !penable && !pwrite;
  end

  // next values of registers, bus answer and stream
  always_comb begin
    next_state      = state;
    next_pipe_a     = pipe_a;
    next_pipe_b     = pipe_b;
    next_sec_mem    = sec_mem;
    next_count_word = count_word;
    next_sent       = sent;
    next_p          = p;
    next_s          = s;
    next_hv         = hv;
    next_sv         = sv;
    next_pready     = psel && !penable;
    next_pslverr    = psel && !penable && !(hit_pipe || hit_sec || hit_reg);
    next_prdata     = dpc_pkg::RST_WORD;
    if (rd) begin
      if (paddr == dpc_pkg::CTRL_OFS) next_prdata = {31'h0000_0000, state != dpc_pkg::S_IDLE};
      else if (paddr == dpc_pkg::COUNT_OFS) next_prdata = count_word;
      else if (paddr == dpc_pkg::SENT_OFS) next_prdata = sent;
      else if (hit_pipe) next_prdata = paddr[2] ? pipe_b[ap] : pipe_a[ap];
      else if (hit_sec) next_prdata = sec_mem[as];
    end
    if (wr) begin
      if (hit_pipe && paddr[2]) next_pipe_b[ap] = pwdata;
      if (hit_pipe && !paddr[2]) next_pipe_a[ap] = pwdata;
      if (hit_sec) next_sec_mem[as] = pwdata;
      if (paddr == dpc_pkg::COUNT_OFS) next_count_word = pwdata;
    end
    case (state)
      dpc_pkg::S_IDLE: begin
        // a new set may start whenever the source is idle, announced or not
        if (wr && paddr == dpc_pkg::CTRL_OFS && pwdata[0]) begin
          next_state = dpc_pkg::S_HDR;
          next_p     = '0;
          next_hv    = 1'b1;
        end
      end
      dpc_pkg::S_HDR: begin
        if (hv && link.hdr_ready) begin
          next_p = p + 1'b1;
          if (p == npm1) begin
            next_hv = 1'b0;
            next_s  = '0;
            next_sv = (nsec != '0);
            next_state = (nsec != '0) ? dpc_pkg::S_SEC : dpc_pkg::S_IDLE;
            if (nsec == '0) next_sent = sent + 32'h0000_0001;
          end
        end
      end
      dpc_pkg::S_SEC: begin
        if (sv && link.sec_ready) begin
          next_s = s + 1'b1;
          if ({1'b0, s} == nsec - 1'b1) begin
            next_sv    = 1'b0;
            next_state = dpc_pkg::S_IDLE;
            next_sent  = sent + 32'h0000_0001;
          end
        end
      end
      default: next_state = dpc_pkg::S_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= dpc_pkg::S_IDLE;
      pipe_a     <= '{default: dpc_pkg::RST_WORD};
      pipe_b     <= '{default: dpc_pkg::RST_WORD};
      sec_mem    <= '{default: dpc_pkg::RST_WORD};
      count_word <= dpc_pkg::RST_WORD;
      sent       <= dpc_pkg::RST_WORD;
      p          <= '0;
      s          <= '0;
      hv         <= 1'b0;
      sv         <= 1'b0;
      prdata     <= dpc_pkg::RST_WORD;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      state      <= next_state;
      pipe_a     <= next_pipe_a;
      pipe_b     <= next_pipe_b;
      sec_mem    <= next_sec_mem;
      count_word <= next_count_word;
      sent       <= next_sent;
      p          <= next_p;
      s          <= next_s;
      hv         <= next_hv;
      sv         <= next_sv;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  // link fields straight from the held tables
  assign link.hdr_valid          = hv;
  assign link.hdr_last           = (p == npm1);
  assign link.list_empty         = (nsec == '0);
  assign link.pipe_width_units   = pipe_a[p][dpc_pkg::PA_WIDTH_LSB +: dpc_pkg::PIPE_W];
  assign link.sections_m1        = pipe_a[p][dpc_pkg::PA_SECM1_LSB +: dpc_pkg::SECM1_W];
  assign link.mult_int_m1        = pipe_a[p][dpc_pkg::PA_MINT_LSB +: dpc_pkg::MINT_W];
  assign link.mult_fract         = pipe_a[p][dpc_pkg::PA_MFR_LSB +: dpc_pkg::MFR_W];
  assign link.invert             = pipe_a[p][dpc_pkg::PA_INV_BIT];
  assign link.tail_pipe          = pipe_a[p][dpc_pkg::PA_TAIL_BIT];
  assign link.codeword_align     = pipe_a[p][dpc_pkg::PA_ALIGN_BIT];
  assign link.reconfig_flag      = pipe_a[p][dpc_pkg::PA_RECFG_BIT];
  assign link.units_per_codeword = pipe_b[p][dpc_pkg::PB_UPC_LSB +: dpc_pkg::UPC_W];
  assign link.stream_identifier  = pipe_b[p][dpc_pkg::PB_SID_LSB +: dpc_pkg::SID_W];
  assign link.sec_valid          = sv;
  assign link.sec_last           = ({1'b0, s} == nsec - 1'b1);
  assign link.half_tap_count_m1  = sec_mem[s][dpc_pkg::SE_HALF_LSB +: dpc_pkg::HALF_W];
  assign link.tap_diff           = sec_mem[s][dpc_pkg::SE_DIFF_LSB +: dpc_pkg::DIFF_W];
  assign link.gap_width          = sec_mem[s][dpc_pkg::SE_GAP_LSB +: dpc_pkg::GAP_W];
endmodule // dpc_param_source

/* dpc_profile_calc.sv */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
// Purpose: derives receiver and transmitter tap delays of one selected pipe
// Assumes: source sends every pipe header, then the whole section list
// Notes: one tap per cycle; old vectors serve lookups until commit
module dpc_profile_calc (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // link
  dpc_link_if.calc                         link,
  // user side
  input  wire logic [dpc_pkg::NPIPE_W-1:0] target_pipe,
  input  wire logic [dpc_pkg::UPC_W-1:0]   interleave_unit_index,
  output logic                             profile_valid,
  output logic                             busy,
  output logic [dpc_pkg::TAP_W-1:0]        max_delay,
  output logic [dpc_pkg::TAP_W-1:0]        rx_delay,
  output logic [dpc_pkg::TAP_W-1:0]        tx_delay,
  output logic [dpc_pkg::SECM1_W:0]        section_count,
  output logic                             combine_allowed,
  output logic                             codeword_align,
  output logic                             reconfig_pending
);
  dpc_pkg::dpc_calc_state_t state, next_state;
  logic [dpc_pkg::TAP_W-1:0]   work [dpc_pkg::NTAP];
  logic [dpc_pkg::TAP_W-1:0]   next_work [dpc_pkg::NTAP];
  logic [dpc_pkg::TAP_W-1:0]   active [dpc_pkg::NTAP];
  logic [dpc_pkg::TAP_W-1:0]   next_active [dpc_pkg::NTAP];
  logic [dpc_pkg::NPIPE_W-1:0] hcnt, next_hcnt;
  logic [dpc_pkg::LIST_W-1:0]  base, next_base, sidx, next_sidx;
  logic [dpc_pkg::SECM1_W:0]   tsec, next_tsec, taken, next_taken, cnt;
  logic [dpc_pkg::MINT_W-1:0]  mint, next_mint;
  logic [dpc_pkg::MFR_W-1:0]   mfr, next_mfr;
  logic                        inv, next_inv, tail, next_tail, seen_last, next_seen_last;
  logic                        align, next_align, recfg, next_recfg;
  logic                        first, next_first;
  logic [dpc_pkg::UPC_W-1:0]   upc, next_upc, upc_act, next_upc_act;
  logic [dpc_pkg::SID_W-1:0]   sid, next_sid;
  logic [dpc_pkg::HALF_W+1:0]  ntaps, next_ntaps, j, next_j;
  logic [dpc_pkg::DIFF_W-1:0]  diff, next_diff;
  logic [dpc_pkg::GAP_W-1:0]   gap, next_gap;
  logic [dpc_pkg::LEN_W-1:0]   inter, next_inter, prev_last, next_prev_last, inter_now;
  logic [dpc_pkg::IDX_W:0]     ptr, next_ptr;
  logic [dpc_pkg::TAP_W-1:0]   last_tap, next_last_tap, tap_now, reord;
  logic [dpc_pkg::LEN_W+dpc_pkg::MFR_W:0] scaled;
  logic [dpc_pkg::TAP_W-1:0]   next_max, next_rx, next_tx;
  logic                        next_pvalid, next_hrdy, next_srdy;
  logic [dpc_pkg::SECM1_W:0]   next_sc;
  logic                        next_comb, next_calign, next_rpend, take;
  logic [dpc_pkg::IDX_W-1:0]   src_i;

  // tap arithmetic of the current step
  always_comb begin
    if (j == '0) inter_now = first ? '0 : dpc_pkg::LEN_W'(prev_last + gap);
    else inter_now = dpc_pkg::LEN_W'(inter + diff);
    scaled  = inter_now * ({1'b0, mfr} + 5'h01);
    // widen both factors first so a long tap cannot wrap in the product
    tap_now = dpc_pkg::TAP_W'(scaled[dpc_pkg::FRACT_BITS +: dpc_pkg::LEN_W+1])
              * dpc_pkg::TAP_W'({1'b0, mint} + 5'h01);
  end

  // sequencing of headers, sections and taps
  always_comb begin
    next_state = state;
    next_work = work;
    next_active = active;
    next_hcnt = hcnt;
    next_base = base;
    next_sidx = sidx;
    next_tsec = tsec;
    next_taken = taken;
    next_mint = mint;
    next_mfr = mfr;
    next_inv = inv;
    next_tail = tail;
    next_seen_last = seen_last;
    next_align = align;
    next_recfg = recfg;
    next_first = first;
    next_upc = upc;
    next_upc_act = upc_act;
    next_sid = sid;
    next_ntaps = ntaps;
    next_j = j;
    next_diff = diff;
    next_gap = gap;
    next_inter = inter;
    next_prev_last = prev_last;
    next_ptr = ptr;
    next_last_tap = last_tap;
    next_pvalid = profile_valid;
    next_max = max_delay;
    next_sc = section_count;
    next_comb = combine_allowed;
    next_calign = codeword_align;
    next_rpend = reconfig_pending;
    cnt = (link.pipe_width_units == '0) ? '0 : {1'b0, link.sections_m1} + 6'h01;
    take = (sidx >= base) && (taken < tsec) && (ptr < 6'(dpc_pkg::NTAP)) && !tail;
    reord = '0;
    src_i = '0;
    case (state)
      dpc_pkg::C_IDLE, dpc_pkg::C_HDRS: begin
        // any new set restarts, flagged in advance or not
        if (link.hdr_valid) begin
          if (state == dpc_pkg::C_IDLE) begin
            next_hcnt = '0;
            next_base = '0;
            next_tsec = '0;
          end
          if (next_hcnt < target_pipe) next_base = next_base + dpc_pkg::LIST_W'(cnt);
          if (next_hcnt == target_pipe) begin
            next_tsec  = cnt;
            next_mint  = link.mult_int_m1;
            next_mfr   = link.mult_fract;
            next_inv   = link.invert;
            next_tail  = link.tail_pipe;
            next_align = link.codeword_align;
            next_recfg = link.reconfig_flag;
            next_upc   = link.units_per_codeword;
            next_sid   = link.stream_identifier;
          end
          next_hcnt = next_hcnt + 1'b1;
          next_sidx = '0;
          next_taken = '0;
          next_ptr = '0;
          next_seen_last = 1'b0;
          next_work = '{default: '0};
          next_last_tap = '0;
          next_prev_last = '0;
          if (link.hdr_last) next_state = link.list_empty ? dpc_pkg::C_COMMIT : dpc_pkg::C_SECS;
          else next_state = dpc_pkg::C_HDRS;
        end
      end
      dpc_pkg::C_SECS: begin
        if (link.sec_valid) begin
          next_sidx = sidx + 1'b1;
          next_seen_last = link.sec_last;
          if (take) begin
            next_ntaps = {({1'b0, link.half_tap_count_m1} + 5'h01), 1'b0};
            next_diff  = link.tap_diff;
            next_gap   = link.gap_width;
            next_first = (taken == '0);
            next_taken = taken + 1'b1;
            next_j     = '0;
            next_state = dpc_pkg::C_TAPS;
          end else if (link.sec_last) begin
            next_state = dpc_pkg::C_COMMIT;
          end
        end
      end
      dpc_pkg::C_TAPS: begin
        next_work[ptr[dpc_pkg::IDX_W-1:0]] = tap_now;
        next_last_tap = tap_now;
        next_inter = inter_now;
        next_ptr = ptr + 1'b1;
        next_j = j + 1'b1;
        // the fixed total of 32 caps a malformed list
        if ((j == ntaps - 1'b1) || (ptr == 6'(dpc_pkg::NTAP - 1))) begin
          next_prev_last = inter_now;
          next_state = seen_last ? dpc_pkg::C_COMMIT : dpc_pkg::C_SECS;
        end
      end
      dpc_pkg::C_COMMIT: begin
        // column-wise readout of the 4x8 matrix, then optional flip
        for (int n = 0; n < dpc_pkg::NTAP; n++) begin
          src_i = inv ? dpc_pkg::IDX_W'(dpc_pkg::NTAP - 1 - n) : dpc_pkg::IDX_W'(n);
          reord = work[{src_i[dpc_pkg::ROW_W-1:0], src_i[dpc_pkg::IDX_W-1:dpc_pkg::ROW_W]}];
          next_active[n] = (tail || tsec == '0) ? '0 : reord;
        end
        next_max = (tail || tsec == '0) ? '0 : last_tap;
        next_upc_act = upc;
        next_sc = tail ? '0 : tsec;
        next_comb = (sid != '0);
        next_calign = align;
        next_rpend = recfg;
        next_pvalid = 1'b1;
        next_state = dpc_pkg::C_IDLE;
      end
      default: next_state = dpc_pkg::C_IDLE;
    endcase
    next_hrdy = (next_state == dpc_pkg::C_IDLE) || (next_state == dpc_pkg::C_HDRS);
    next_srdy = (next_state == dpc_pkg::C_SECS);
  end

  // delay lookup by interleave_unit index, period 32
  always_comb begin
    next_rx = (interleave_unit_index < upc_act) ? active[interleave_unit_index[dpc_pkg::IDX_W-1:0]] : '0;
    next_tx = (interleave_unit_index < upc_act) ? dpc_pkg::TAP_W'(max_delay - next_rx) : '0;
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dpc_pkg::C_IDLE;
      work <= '{default: '0};
      active <= '{default: '0};
      {hcnt, base, sidx, tsec, taken} <= '0;
      {mint, mfr, inv, tail, seen_last, align, recfg, first} <= '0;
      {upc, upc_act, sid, ntaps, j, diff, gap} <= '0;
      {inter, prev_last, ptr, last_tap} <= '0;
      {profile_valid, max_delay, rx_delay, tx_delay, section_count} <= '0;
      {combine_allowed, codeword_align, reconfig_pending, busy} <= '0;
      link.hdr_ready <= 1'b1;
      link.sec_ready <= 1'b0;
    end else begin
      state <= next_state;
      work <= next_work;
      active <= next_active;
      {hcnt, base, sidx, tsec, taken} <= {next_hcnt, next_base, next_sidx, next_tsec, next_taken};
      {mint, mfr, inv, tail, seen_last, align, recfg, first} <=
        {next_mint, next_mfr, next_inv, next_tail, next_seen_last, next_align, next_recfg, next_first};
      {upc, upc_act, sid, ntaps, j, diff, gap} <= {next_upc, next_upc_act, next_sid, next_ntaps, next_j, next_diff, next_gap};
      {inter, prev_last, ptr, last_tap} <= {next_inter, next_prev_last, next_ptr, next_last_tap};
      {profile_valid, max_delay, rx_delay, tx_delay, section_count} <=
        {next_pvalid, next_max, next_rx, next_tx, next_sc};
      {combine_allowed, codeword_align, reconfig_pending} <= {next_comb, next_calign, next_rpend};
      busy <= (next_state != dpc_pkg::C_IDLE);
      link.hdr_ready <= next_hrdy;
      link.sec_ready <= next_srdy;
    end
  end
endmodule // dpc_profile_calc

/* dpc_monitor.sv */
// Purpose: protocol checker on the link between source and calculator
// Assumes: one clock pclk, asynchronous active-low reset presetn
// Notes: instantiated beside the link, watches plain signals
`timescale 1ns/1ps
module dpc_monitor (
  // clock and reset
  input wire logic                         pclk,
  input wire logic                         presetn,
  // header handshake
  input wire logic                         hdr_valid,
  input wire logic                         hdr_ready,
  input wire logic                         hdr_last,
  input wire logic                         list_empty,
  input wire logic [dpc_pkg::PIPE_W-1:0]   pipe_width_units,
  input wire logic [dpc_pkg::SECM1_W-1:0]  sections_m1,
  // section handshake
  input wire logic                         sec_valid,
  input wire logic                         sec_ready,
  input wire logic                         sec_last,
  input wire logic [dpc_pkg::HALF_W-1:0]   half_tap_count_m1,
  input wire logic [dpc_pkg::DIFF_W-1:0]   tap_diff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // offered items hold until taken, headers precede sections
  a_hdr_hold_fields: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(pipe_width_units) && $stable(sections_m1))
    else $error("header changed before acceptance");
  a_sec_hold_fields: assert property (sec_valid && !sec_ready |=> sec_valid && $stable(half_tap_count_m1) && $stable(tap_diff))
    else $error("section changed before acceptance");
  a_hdr_sec_apart: assert property (hdr_valid |-> !sec_valid)
    else $error("header and section offered together");
  a_sec_blocks_hdr: assert property (sec_valid |-> !hdr_ready)
    else $error("new header accepted during section phase");
  a_empty_no_list: assert property (hdr_valid && hdr_ready && hdr_last && list_empty |=> !sec_valid [*2])
    else $error("section offered after empty list");
  a_hdr_taken_soon: assert property (hdr_valid |-> ##[0:300] hdr_ready)
    else $error("header never accepted");
  a_sec_taken_soon: assert property (sec_valid |-> ##[0:40] sec_ready)
    else $error("section stalled beyond one tap run");
  a_list_ends_last: assert property (sec_valid && sec_ready && sec_last |=> !sec_valid)
    else $error("section offered after last entry");
endmodule // dpc_monitor

/* disperser_profile_calc_tb.sv */
// Purpose: self-checking bench of source and calculator joined by the link
// Assumes: pclk period 100 ns, presetn held low 16 cycles
// Notes: expectations rebuilt from the words loaded over apb
`timescale 1ns/1ps
module disperser_profile_calc_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0, unit_index = 0;
  logic [31:0] pwdata = 0, prdata, q, pa[2], pb[2], se[4];
  logic [2:0]  target_pipe = 0;
  logic        pv, busy, cw, rp, ca;
  logic [23:0] md, rx, tx, em, hold = 0, er[32];
  logic [5:0]  sc;
  int          miscompares = 0, samples_checked = 0;
  // clock
  always #50 pclk = ~pclk;
  dpc_link_if link ();
  dpc_param_source dpc_param_source_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  dpc_profile_calc dpc_profile_calc_i (.pclk(pclk), .presetn(presetn), .link(link), .target_pipe(target_pipe),
    .interleave_unit_index(unit_index), .profile_valid(pv), .busy(busy), .max_delay(md), .rx_delay(rx), .tx_delay(tx),
    .section_count(sc), .combine_allowed(ca), .codeword_align(cw), .reconfig_pending(rp));
  dpc_monitor dpc_monitor_i (.pclk(pclk), .presetn(presetn), .hdr_valid(link.hdr_valid), .hdr_ready(link.hdr_ready),
    .hdr_last(link.hdr_last), .list_empty(link.list_empty), .pipe_width_units(link.pipe_width_units),
    .sections_m1(link.sections_m1), .sec_valid(link.sec_valid), .sec_ready(link.sec_ready),
    .sec_last(link.sec_last), .half_tap_count_m1(link.half_tap_count_m1), .tap_diff(link.tap_diff));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // request stands until pready is seen high at a rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // load tables, start, old profile must serve lookups until commit
  task automatic run(input int np, input int ns, input logic [2:0] t);
    target_pipe <= t;
    for (int p = 0; p < np; p++) begin
      apb(dpc_pkg::PIPE_BASE + 12'(8 * p), 1, pa[p]);
      apb(dpc_pkg::PIPE_BASE + 12'(8 * p + 4), 1, pb[p]);
    end
    for (int i = 0; i < ns; i++) apb(dpc_pkg::SEC_BASE + 12'(4 * i), 1, se[i]);
    apb(dpc_pkg::COUNT_OFS, 1, (32'(ns) << 8) | 32'(np - 1));
    apb(dpc_pkg::CTRL_OFS, 1, 32'h0000_0001);
    for (int k = 0; k < 50 && busy !== 1'b1; k++) @(negedge pclk);
    while (busy === 1'b1) begin
      cmp("held rx", 32'(hold), 32'(rx));
      @(negedge pclk);
    end
  endtask
  // rebuild the profile of pipe t and sweep unit indices 0 through units_per_codeword
  task automatic check(input int t);
    int m, n, k, off, pr, inter, x, u;
    logic [23:0] v[32], r;
    m = 0;
    k = 0;
    pr = 0;
    foreach (v[i]) v[i] = 0;
    for (int p = 0; p < t; p++) if (pa[p][7:0] != 0) m += pa[p][12:8] + 1;
    n = (pa[t][7:0] == 0 || pa[t][25]) ? 0 : pa[t][12:8] + 1;
    for (int s = 0; s < n; s++) begin
      off = (s == 0) ? 0 : pr + se[m + s][31:16];
      for (int j = 0; j < (se[m + s][3:0] + 1) * 2 && k < 32; j++) begin
        inter = off + j * se[m + s][15:8];
        v[k] = 24'((pa[t][19:16] + 1) * ((inter * (pa[t][23:20] + 1)) >> 4));
        pr = inter;
        k++;
      end
    end
    em = v[31];
    for (int i = 0; i < 32; i++) begin
      x = pa[t][24] ? 31 - i : i;
      er[i] = v[(x % 4) * 8 + x / 4];
    end
    repeat (2) @(negedge pclk);
    cmp("max delay", 32'(em), 32'(md));
    cmp("sections", 32'(n), 32'(sc));
    cmp("combine", 32'(pb[t][23:16] != 0), 32'(ca));
    cmp("align", 32'(pa[t][26]), 32'(cw));
    cmp("reconfig", 32'(pa[t][27]), 32'(rp));
    for (u = 0; u <= pb[t][11:0]; u++) begin
      @(posedge pclk) unit_index <= 12'(u);
      @(posedge pclk);
      @(negedge pclk);
      r = (u < pb[t][11:0]) ? er[u % 32] : 24'h00_0000;
      cmp("rx delay", 32'(r), 32'(rx));
      cmp("tx delay", 32'((u < pb[t][11:0]) ? em - r : 24'h00_0000), 32'(tx));
    end
    hold = er[1];
    @(posedge pclk) unit_index <= 12'h001;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(12'h0FC, 0, 32'h0000_0000);
    cmp("unmapped err", 32'h0000_0001, 32'(err));
    cmp("unmapped data", 32'h0000_0000, q);
    pa[0] = 32'h0871_0104;
    pb[0] = 32'h0000_0028;
    pa[1] = 32'h0200_0000;
    pb[1] = 32'h0000_0000;
    se[0] = 32'h0000_0307;
    se[1] = 32'h0005_0207;
    run(2, 2, 0);
    check(0);
    pa[0] = 32'h0000_0300;
    pa[1] = 32'h01F0_0003;
    pb[1] = 32'h0005_0014;
    se[0] = 32'h0000_010F;
    run(2, 1, 1);
    check(1);
    pa[0] = 32'h0600_0005;
    pb[0] = 32'h0000_0008;
    run(1, 0, 0);
    check(0);
    apb(dpc_pkg::SENT_OFS, 0, 32'h0000_0000);
    cmp("sets sent", 32'h0000_0003, q);
    results;
  end
  // watchdog
  initial begin
    repeat (12000) @(posedge pclk);
    miscompares++;
    results;
  end
endmodule // disperser_profile_calc_tb
